/* File: design/aslmc_pkg.sv */
// Constants and types for the aux switch / lane map control block.
// Assumes one 100 MHz clock and APB register access.
package aslmc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_FAST = 8'h00;
	localparam logic [7:0] ADDR_AUX  = 8'h04;
	localparam logic [7:0] ADDR_TX   = 8'h08;
	localparam logic [7:0] ADDR_MAPA = 8'h0C;
	localparam logic [7:0] ADDR_MAPB = 8'h10;
	localparam logic [7:0] ADDR_INV  = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;
	localparam int FAST_EN_BIT  = 6;
	localparam int FAST_SEL_BIT = 0;
	localparam int AUX_LOCK_BIT = 7;
	localparam int AUX_EN_BIT   = 6;
	localparam int AUX_SEL_BIT  = 0;
	localparam int DRIVE_BIT    = 2;
	localparam logic [7:0] MAP_RST = 8'hE4;
	localparam logic [7:0] INV_RST = 8'h00;
	// ----------------------------------------
	// Timing and levels
	// ----------------------------------------
	localparam int CLK_MHZ     = 100;
	localparam int HPD_LOW_MS  = 100;
	localparam int HPD_CYC_DEF = HPD_LOW_MS * 1000 * CLK_MHZ + 1;
	localparam logic [6:0] BASE_LO_HALF_MA = 7'h14;
	localparam logic [6:0] BASE_HI_HALF_MA = 7'h28;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [3:0] aslmc_lane_type;
	typedef enum logic [1:0] {
		ASLMC_HPD_IDLE = 2'b00,
		ASLMC_HPD_LOW  = 2'b01
	} aslmc_hpd_type;
	typedef struct packed {
		logic       fast_en;
		logic       fast_sel;
		logic       aux_lock;
		logic       aux_en;
		logic       aux_sel;
		logic [1:0] boost;
		logic       drive_hi;
		logic [7:0] map_a;
		logic [7:0] map_b;
		logic [7:0] inv;
	} aslmc_cfg_type;
	localparam aslmc_cfg_type CFG_RST = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
		2'b00, 1'b1, MAP_RST, MAP_RST, INV_RST};
	typedef struct packed {
		aslmc_cfg_type  cfg;
		logic           pready;
		logic           pslverr;
		logic [31:0]    prdata;
		aslmc_hpd_type  hst;
		logic [23:0]    hcnt;
		logic           last_fast;
		logic           last_aux;
		logic [1:0]     hpd_oe_n;
		aslmc_lane_type tmds_out;
		logic           tmds_oe_n;
		logic [1:0]     a_oe_n;
		logic [1:0]     b_oe_n;
		logic           cec_src_oe_n;
		logic [2:0]     dn_oe_n;
		logic [2:0]     hold_up;
		logic [2:0]     hold_dn;
		logic [2:0]     boost_db;
		logic [6:0]     drive_half_ma;
		logic           cec_pullup_en;
		logic           pin_low;
	} aslmc_state_type;
endpackage : aslmc_pkg

/* File: design/aslmc_top.sv */
// Aux switch, hot plug pulse, output level and lane map control.
// Assumes an APB master on pclk; pins are sampled synchronously.
`timescale 1ns/1ps
module aslmc_top #(
	parameter int unsigned HPD_LOW_CYCLES = aslmc_pkg::HPD_CYC_DEF
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Lane inputs and output
	input  wire aslmc_pkg::aslmc_lane_type source_a_lanes,
	input  wire aslmc_pkg::aslmc_lane_type source_b_lanes,
	output aslmc_pkg::aslmc_lane_type tmds_out,
	output logic                      tmds_oe_n,
	// Display bus pins, bit 0 clock, bit 1 data
	input  wire logic [1:0]           display_bus_port_a_in,
	output logic [1:0]                display_bus_port_a_out,
	output logic [1:0]                display_bus_port_a_oe_n,
	input  wire logic [1:0]           display_bus_port_b_in,
	output logic [1:0]                display_bus_port_b_out,
	output logic [1:0]                display_bus_port_b_oe_n,
	input  wire logic [1:0]           display_bus_common_in,
	output logic [1:0]                display_bus_common_out,
	output logic [1:0]                display_bus_common_oe_n,
	// CEC pins
	input  wire logic                 cec_source_in,
	output logic                      cec_source_out,
	output logic                      cec_source_oe_n,
	input  wire logic                 cec_sink_in,
	output logic                      cec_sink_out,
	output logic                      cec_sink_oe_n,
	output logic                      cec_pullup_en,
	// Hot plug pins, bit 0 source A
	output logic [1:0]                hpd_out,
	output logic [1:0]                hpd_oe_n,
	// Output level settings
	output logic [2:0]                boost_db,
	output logic [6:0]                drive_half_ma
);
	import aslmc_pkg::*;

	localparam logic [23:0] HPD_LAST = 24'(HPD_LOW_CYCLES - 1);

	aslmc_state_type st;
	aslmc_state_type next_st;

	logic           eff_fast;
	logic           eff_aux;
	logic           sel_change;
	aslmc_lane_type lane_in;
	logic [7:0]     lane_map;
	aslmc_lane_type lane_inv;
	aslmc_lane_type mapped;
	logic [3:0][3:0] hit;
	logic [2:0]     up_low;
	logic [2:0]     dn_low;
	logic [2:0]     drv_up;
	logic [2:0]     drv_dn;
	logic [2:0]     line_en;
	logic [2:0]     next_drv_up;
	logic [2:0]     next_drv_dn;
	logic [7:0]     rd_fast;
	logic [7:0]     rd_aux;
	logic [7:0]     rd_tx;
	logic [31:0]    rd_stat;
	logic           wr_ok;

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	// Effective selects
	assign eff_fast   = st.cfg.fast_sel;
	assign eff_aux    = st.cfg.aux_lock ? st.cfg.fast_sel : st.cfg.aux_sel;
	assign sel_change = (eff_fast != st.last_fast) | (eff_aux != st.last_aux);

	// ----------------------------------------
	// Lane mapping
	// ----------------------------------------
	// Active source lanes and its map
	assign lane_in  = eff_fast ? source_b_lanes : source_a_lanes;
	assign lane_map = eff_fast ? st.cfg.map_b : st.cfg.map_a;
	assign lane_inv = eff_fast ? st.cfg.inv[7:4] : st.cfg.inv[3:0];

	// Each input lane lands on the output lane its field names
	genvar gj, gi;
	generate
		for (gj = 0; gj < 4; gj++) begin : g_out
			for (gi = 0; gi < 4; gi++) begin : g_in
				assign hit[gj][gi] = (lane_map[2*gi +: 2] == 2'(gj)) &
					(lane_in[gi] ^ lane_inv[gi]);
			end
			assign mapped[gj] = |hit[gj];
		end
	endgenerate

	// ----------------------------------------
	// Open-drain buffers
	// ----------------------------------------
	// Bits 0,1 display bus via selected port, bit 2 CEC
	assign up_low  = ~{cec_source_in, eff_aux ? display_bus_port_b_in
		: display_bus_port_a_in};
	assign dn_low  = ~{cec_sink_in, display_bus_common_in};
	assign drv_up  = ~{st.cec_src_oe_n, eff_aux ? st.b_oe_n : st.a_oe_n};
	assign drv_dn  = ~st.dn_oe_n;
	assign line_en = {1'b1, st.cfg.aux_en, st.cfg.aux_en};

	// Low is passed on only where it did not come from us
	generate
		for (gi = 0; gi < 3; gi++) begin : g_line
			assign next_drv_dn[gi] = line_en[gi] & up_low[gi] & ~drv_up[gi] &
				~st.hold_up[gi];
			assign next_drv_up[gi] = line_en[gi] & dn_low[gi] & ~drv_dn[gi] &
				~st.hold_dn[gi];
		end
	endgenerate

	// ----------------------------------------
	// Register read views
	// ----------------------------------------
	// Read bytes and status word
	always_comb begin
		rd_fast = '0;
		rd_fast[FAST_EN_BIT]  = st.cfg.fast_en;
		rd_fast[FAST_SEL_BIT] = st.cfg.fast_sel;
		rd_aux = '0;
		rd_aux[AUX_LOCK_BIT]  = st.cfg.aux_lock;
		rd_aux[AUX_EN_BIT]    = st.cfg.aux_en;
		rd_aux[AUX_SEL_BIT]   = st.cfg.aux_sel;
		rd_tx = '0;
		rd_tx[1:0]            = st.cfg.boost;
		rd_tx[DRIVE_BIT]      = st.cfg.drive_hi;
		rd_stat = {17'h0, st.drive_half_ma, 1'b0, st.boost_db, 1'b0,
			st.hst == ASLMC_HPD_LOW, eff_aux, eff_fast};
	end

	// Write at access edge of a mapped address
	assign wr_ok = psel & penable & st.pready & pwrite & ~st.pslverr;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		// APB answers at the first access edge
		next_st.pready  = psel & ~penable;
		next_st.pslverr = 1'b0;
		next_st.prdata  = '0;
		if (psel & ~penable) begin
			case (paddr)
				ADDR_FAST: next_st.prdata = {24'h0, rd_fast};
				ADDR_AUX:  next_st.prdata = {24'h0, rd_aux};
				ADDR_TX:   next_st.prdata = {24'h0, rd_tx};
				ADDR_MAPA: next_st.prdata = {24'h0, st.cfg.map_a};
				ADDR_MAPB: next_st.prdata = {24'h0, st.cfg.map_b};
				ADDR_INV:  next_st.prdata = {24'h0, st.cfg.inv};
				ADDR_STAT: next_st.prdata = rd_stat;
				default:   next_st.pslverr = 1'b1;
			endcase
		end
		// Register writes
		if (wr_ok) begin
			case (paddr)
				ADDR_FAST: begin
					next_st.cfg.fast_en  = pwdata[FAST_EN_BIT];
					next_st.cfg.fast_sel = pwdata[FAST_SEL_BIT];
				end
				ADDR_AUX: begin
					next_st.cfg.aux_lock = pwdata[AUX_LOCK_BIT];
					next_st.cfg.aux_en   = pwdata[AUX_EN_BIT];
					next_st.cfg.aux_sel  = pwdata[AUX_SEL_BIT];
				end
				ADDR_TX: begin
					next_st.cfg.boost    = pwdata[1:0];
					next_st.cfg.drive_hi = pwdata[DRIVE_BIT];
				end
				ADDR_MAPA: next_st.cfg.map_a = pwdata[7:0];
				ADDR_MAPB: next_st.cfg.map_b = pwdata[7:0];
				ADDR_INV:  next_st.cfg.inv   = pwdata[7:0];
				default: ;
			endcase
		end
		// Hot plug pulse timer
		next_st.last_fast = eff_fast;
		next_st.last_aux  = eff_aux;
		case (st.hst)
			ASLMC_HPD_IDLE: begin
				if (sel_change) begin
					next_st.hst      = ASLMC_HPD_LOW;
					next_st.hcnt     = '0;
					next_st.hpd_oe_n = 2'b00;
				end
			end
			ASLMC_HPD_LOW: begin
				if (sel_change) begin
					next_st.hcnt = '0;
				end else if (st.hcnt == HPD_LAST) begin
					next_st.hst      = ASLMC_HPD_IDLE;
					next_st.hpd_oe_n = 2'b11;
				end else begin
					next_st.hcnt = st.hcnt + 24'h000001;
				end
			end
			default: begin
				next_st.hst      = ASLMC_HPD_IDLE;
				next_st.hpd_oe_n = 2'b11;
			end
		endcase
		// Lane outputs
		next_st.tmds_out  = mapped;
		next_st.tmds_oe_n = ~st.cfg.fast_en;
		// Buffer drives; unselected port left released
		next_st.a_oe_n  = ~(next_drv_up[1:0] & {2{~eff_aux}});
		next_st.b_oe_n  = ~(next_drv_up[1:0] & {2{eff_aux}});
		next_st.cec_src_oe_n = ~next_drv_up[2];
		next_st.dn_oe_n = ~next_drv_dn;
		next_st.hold_up = drv_up;
		next_st.hold_dn = drv_dn;
		// Output level: boost adds a quarter, a half or all of the base current
		next_st.boost_db = {st.cfg.boost, 1'b0};
		next_st.drive_half_ma = st.cfg.drive_hi ? BASE_HI_HALF_MA : BASE_LO_HALF_MA;
		case (st.cfg.boost)
			2'h1: next_st.drive_half_ma = next_st.drive_half_ma +
				(next_st.drive_half_ma >> 2);
			2'h2: next_st.drive_half_ma = next_st.drive_half_ma +
				(next_st.drive_half_ma >> 1);
			2'h3: next_st.drive_half_ma = next_st.drive_half_ma << 1;
			default: ;
		endcase
		next_st.cec_pullup_en = 1'b1;
		next_st.pin_low       = 1'b0;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st               <= '0;
			st.cfg           <= CFG_RST;
			st.hpd_oe_n      <= 2'b11;
			st.a_oe_n        <= 2'b11;
			st.b_oe_n        <= 2'b11;
			st.cec_src_oe_n  <= 1'b1;
			st.dn_oe_n       <= 3'b111;
			st.drive_half_ma <= BASE_HI_HALF_MA;
			st.cec_pullup_en <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign prdata                  = st.prdata;
	assign pready                  = st.pready;
	assign pslverr                 = st.pslverr;
	assign tmds_out                = st.tmds_out;
	assign tmds_oe_n               = st.tmds_oe_n;
	assign display_bus_port_a_out  = {2{st.pin_low}};
	assign display_bus_port_a_oe_n = st.a_oe_n;
	assign display_bus_port_b_out  = {2{st.pin_low}};
	assign display_bus_port_b_oe_n = st.b_oe_n;
	assign display_bus_common_out  = {2{st.pin_low}};
	assign display_bus_common_oe_n = st.dn_oe_n[1:0];
	assign cec_source_out          = st.pin_low;
	assign cec_source_oe_n         = st.cec_src_oe_n;
	assign cec_sink_out            = st.pin_low;
	assign cec_sink_oe_n           = st.dn_oe_n[2];
	assign cec_pullup_en           = st.cec_pullup_en;
	assign hpd_out                 = {2{st.pin_low}};
	assign hpd_oe_n                = st.hpd_oe_n;
	assign boost_db                = st.boost_db;
	assign drive_half_ma           = st.drive_half_ma;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_port_a_pulls;
		!eff_aux && st.cfg.aux_en && !display_bus_port_a_in[0] &&
			st.a_oe_n[0] && !st.hold_up[0];
	endsequence
	sequence s_sink_pulls;
		!cec_sink_in && st.dn_oe_n[2] && !st.hold_dn[2];
	endsequence

	AST_HPD_START: assert property ($changed(eff_fast) |=> hpd_oe_n == 2'b00)
		else $error("hot plug not pulled low after switch");
	AST_HPD_LEN: assert property ($rose(hpd_oe_n[0]) |-> $past(st.hcnt) == HPD_LAST)
		else $error("hot plug low pulse ended early");
	AST_LOCK: assert property (st.cfg.aux_lock && $changed(st.cfg.fast_sel)
		|-> $changed(eff_aux))
		else $error("aux select did not follow fast select");
	AST_UNSEL_HIZ: assert property (!eff_aux |=> display_bus_port_b_oe_n == 2'b11)
		else $error("unselected port driven");
	AST_DBUS_PASS: assert property (s_port_a_pulls |=> !display_bus_common_oe_n[0])
		else $error("display bus low not passed to common");
	AST_CEC_PASS: assert property (s_sink_pulls |=> !cec_source_oe_n && cec_pullup_en)
		else $error("cec low not passed to source side");
	AST_BOOST: assert property (st.cfg.boost == 2'h3 && st.cfg.drive_hi
		|=> boost_db == 3'h6 && drive_half_ma == 7'h50)
		else $error("boost level wrong");
	AST_MAP: assert property (!eff_fast && st.cfg.map_a == 8'h1B && st.cfg.inv == 8'h00
		|=> tmds_out[0] == $past(source_a_lanes[3]))
		else $error("lane map wrong");
	AST_INV: assert property (eff_fast && st.cfg.map_b == 8'hE4 && st.cfg.inv == 8'hF0
		|=> tmds_out == ~$past(source_b_lanes))
		else $error("lane polarity wrong");
	AST_TRI: assert property (!st.cfg.fast_en |=> tmds_oe_n)
		else $error("outputs not tristated");
	AST_RESTART: assert property (st.hst == ASLMC_HPD_LOW && sel_change
		|=> st.hcnt == 24'h000000 && hpd_oe_n == 2'b00)
		else $error("hot plug timer not restarted");
endmodule : aslmc_top

/* File: tb/aslmc_partner.sv */
// Far-side model: two video sources and one display sink on the open-drain lines.
// Assumes pull-ups on every line; the bench commands each far-side pull-low.
`timescale 1ns/1ps
module aslmc_partner (
	// Design pin enables, low pulls the wire
	input  wire logic [1:0] a_oe_n,
	input  wire logic [1:0] b_oe_n,
	input  wire logic [1:0] c_oe_n,
	input  wire logic       cs_oe_n,
	input  wire logic       ck_oe_n,
	// Far-side pull-low commands
	input  wire logic [1:0] pull_a,
	input  wire logic [1:0] pull_b,
	input  wire logic [1:0] pull_c,
	input  wire logic       pull_s,
	input  wire logic       pull_k,
	// Resolved wire levels
	output logic [1:0]      a_in,
	output logic [1:0]      b_in,
	output logic [1:0]      c_in,
	output logic            cs_in,
	output logic            ck_in
);
	// Wired-AND, released lines rise to the pull-up level
	assign a_in  = a_oe_n & ~pull_a;
	assign b_in  = b_oe_n & ~pull_b;
	assign c_in  = c_oe_n & ~pull_c;
	assign cs_in = cs_oe_n & ~pull_s;
	assign ck_in = ck_oe_n & ~pull_k;
endmodule : aslmc_partner

/* File: tb/aslmc_top_tb.sv */
// Self-checking bench for the aux switch and lane map control block.
// Assumes the partner model resolves the display bus and CEC wire levels.
`timescale 1ns/1ps
module aslmc_top_tb;
	import aslmc_pkg::*;
	localparam int HPD_N = 20;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  src_a, src_b, tmds_out;
	logic [1:0]  a_in, a_oe_n, b_in, b_oe_n, c_in, c_oe_n, pull_a, pull_b, pull_c, hpd_oe_n;
	logic        tmds_oe_n, cs_in, cs_oe_n, ck_in, ck_oe_n, pull_s, pull_k, cec_pullup_en;
	logic [2:0]  boost_db;
	logic [6:0]  drive_half_ma;
	logic [1:0]  a_out, b_out, c_out, hpd_out;
	logic        cs_out, ck_out;
	int          fail_count = 0;
	int          checks_done = 0;

	aslmc_top #(.HPD_LOW_CYCLES(HPD_N)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .source_a_lanes(src_a),
		.source_b_lanes(src_b), .tmds_out(tmds_out), .tmds_oe_n(tmds_oe_n),
		.display_bus_port_a_in(a_in), .display_bus_port_a_out(a_out),
		.display_bus_port_a_oe_n(a_oe_n), .display_bus_port_b_in(b_in),
		.display_bus_port_b_out(b_out), .display_bus_port_b_oe_n(b_oe_n),
		.display_bus_common_in(c_in), .display_bus_common_out(c_out),
		.display_bus_common_oe_n(c_oe_n), .cec_source_in(cs_in),
		.cec_source_out(cs_out), .cec_source_oe_n(cs_oe_n), .cec_sink_in(ck_in),
		.cec_sink_out(ck_out), .cec_sink_oe_n(ck_oe_n), .cec_pullup_en(cec_pullup_en),
		.hpd_out(hpd_out), .hpd_oe_n(hpd_oe_n), .boost_db(boost_db),
		.drive_half_ma(drive_half_ma)
	);
	aslmc_partner partner_u (
		.a_oe_n(a_oe_n), .b_oe_n(b_oe_n), .c_oe_n(c_oe_n), .cs_oe_n(cs_oe_n),
		.ck_oe_n(ck_oe_n), .pull_a(pull_a), .pull_b(pull_b), .pull_c(pull_c),
		.pull_s(pull_s), .pull_k(pull_k), .a_in(a_in), .b_in(b_in), .c_in(c_in),
		.cs_in(cs_in), .ck_in(ck_in)
	);

	// Clock, 100 MHz
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("counts: checks=%0d mismatches=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// APB transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
	endtask : apb

	task automatic settle();
		repeat (5) @(posedge pclk);
	endtask : settle

	task automatic t_reset();
		logic [7:0] ad [7] = '{ADDR_FAST, ADDR_AUX, ADDR_TX, ADDR_MAPA, ADDR_MAPB, ADDR_INV, 8'h1C};
		logic [7:0] ex [7] = '{8'h40, 8'hC0, 8'h04, MAP_RST, MAP_RST, INV_RST, 8'h00};
		chk(32'(hpd_oe_n), 32'h3);
		chk(32'(cec_pullup_en), 32'h1);
		chk(32'({a_out, b_out, c_out, hpd_out, cs_out, ck_out}), 32'h0);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, ad[i], 32'h0);
			chk(rd, 32'(ex[i]));
			chk(32'(er), 32'(i == 6));
		end
		$display("test reset_defaults done");
	endtask : t_reset

	task automatic t_boost();
		logic [7:0] lo [4] = '{8'h14, 8'h19, 8'h1E, 8'h28};
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ADDR_TX, 32'(i));
			settle();
			chk(32'(boost_db), 32'(2 * (i % 4)));
			chk(32'(drive_half_ma), 32'(lo[i % 4]) << (i / 4));
		end
		$display("test boost_drive done");
	endtask : t_boost

	task automatic t_lanes();
		apb(1'b1, ADDR_MAPA, 32'h1B);
		apb(1'b1, ADDR_INV, 32'h01);
		src_a <= 4'b0011;
		settle();
		chk(32'(tmds_out), 32'h4);
		src_a <= 4'b1000;
		settle();
		chk(32'(tmds_out), 32'h9);
		chk(32'(tmds_oe_n), 32'h0);
		$display("test lane_map done");
	endtask : t_lanes

	// Waits out a hot plug low pulse, bounded, returns cycles counted
	task automatic hpd_len(output int len);
		len = 0;
		while (hpd_oe_n === 2'b00 && len < 100) begin
			@(posedge pclk);
			len++;
		end
		if (hpd_oe_n === 2'b00) begin
			fail_count++;
			give_verdict();
		end
	endtask : hpd_len

	task automatic t_switch();
		int n;
		int len;
		n = 0;
		apb(1'b1, ADDR_FAST, 32'h41);
		while (hpd_oe_n !== 2'b00 && n < 4) begin
			@(posedge pclk);
			n++;
		end
		if (hpd_oe_n !== 2'b00) begin
			fail_count++;
			give_verdict();
		end
		chk(32'(hpd_out), 32'h0);
		hpd_len(len);
		chk(32'(len), 32'(HPD_N));
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd, 32'h5063);
		apb(1'b1, ADDR_FAST, 32'h40);
		apb(1'b1, ADDR_FAST, 32'h41);
		// Restart lands one edge after the write; counting starts at the write
		hpd_len(len);
		chk(32'(len), 32'(HPD_N + 2));
		src_b <= 4'b1010;
		settle();
		chk(32'(tmds_out), 32'hA);
		apb(1'b1, ADDR_INV, 32'hF0);
		settle();
		chk(32'(tmds_out), 32'h5);
		$display("test source_switch done");
	endtask : t_switch

	task automatic t_bus();
		pull_b <= 2'b01;
		settle();
		chk(32'({c_oe_n, a_oe_n}), 32'hB);
		pull_b <= 2'b00;
		settle();
		pull_c <= 2'b10;
		settle();
		chk(32'({b_oe_n, a_oe_n, c_oe_n}), 32'h1F);
		pull_c <= 2'b00;
		pull_a <= 2'b11;
		settle();
		chk(32'({c_oe_n, a_oe_n, b_oe_n}), 32'h3F);
		pull_a <= 2'b00;
		pull_k <= 1'b1;
		settle();
		chk(32'({cs_oe_n, ck_oe_n}), 32'h1);
		pull_k <= 1'b0;
		settle();
		chk(32'({cs_oe_n, ck_oe_n}), 32'h3);
		pull_s <= 1'b1;
		settle();
		chk(32'({cs_oe_n, ck_oe_n}), 32'h2);
		pull_s <= 1'b0;
		settle();
		// Lock off, aux select port A
		apb(1'b1, ADDR_AUX, 32'h40);
		pull_a <= 2'b01;
		settle();
		chk(32'({c_oe_n, b_oe_n}), 32'hB);
		pull_a <= 2'b00;
		// Aux enable off, display bus left idle
		apb(1'b1, ADDR_AUX, 32'h00);
		pull_a <= 2'b01;
		settle();
		chk(32'({c_oe_n, a_oe_n}), 32'hF);
		pull_a <= 2'b00;
		apb(1'b1, ADDR_FAST, 32'h01);
		settle();
		chk(32'(tmds_oe_n), 32'h1);
		$display("test aux_bus done");
	endtask : t_bus

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, pull_s, pull_k} = 6'h00;
		{paddr, pwdata, src_a, src_b, pull_a, pull_b, pull_c} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_boost();
		t_lanes();
		t_switch();
		t_bus();
		give_verdict();
	end
endmodule : aslmc_top_tb
